// ==== src/rxcp_pkg.sv ====
package rxcp_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0]  REG_CTRL_OFS     = 8'h00;
  localparam logic [7:0]  REG_MAXLEN_OFS   = 8'h04;
  localparam logic [7:0]  REG_FRAMES_OFS   = 8'h08;
  localparam logic [7:0]  REG_ERRFRM_OFS   = 8'h0C;
  localparam int          CTRL_PT_BIT      = 0;
  localparam logic [15:0] MAXLEN_RST       = 16'h05EE;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_DECERR      = 2'h3;

  // ==========================================================================
  // Frame limits and field positions
  // ==========================================================================
  localparam logic [15:0] RUNT_MAX_BYTES   = 16'h0008;
  localparam logic [15:0] MIN_FRAME_BYTES  = 16'h0040;
  localparam logic [15:0] LEN_FIELD_MAX    = 16'h05DC;
  localparam logic [15:0] HDR_FCS_BYTES    = 16'h0012;
  localparam logic [15:0] POS_DA0          = 16'h0000;
  localparam logic [15:0] POS_TYPE_HI      = 16'h000C;
  localparam logic [15:0] POS_TYPE_LO      = 16'h000D;
  localparam logic [15:0] POS_OPC_HI       = 16'h000E;
  localparam logic [15:0] POS_OPC_LO       = 16'h000F;
  localparam logic [15:0] TYPE_MAC_CTRL    = 16'h8808;
  localparam logic [15:0] OPC_PAUSE        = 16'h0001;
  localparam logic [15:0] TPID_C           = 16'h8100;
  localparam logic [15:0] TPID_S           = 16'h88A8;
  localparam logic [15:0] TPID_Q           = 16'h9100;
  localparam int          PRE_PORT_DATA_W  = 128;
  localparam int          PRE_W            = 64;

  // ==========================================================================
  // Error and status bit positions
  // ==========================================================================
  localparam int ERR_MALFORMED = 0;
  localparam int ERR_CRC       = 1;
  localparam int ERR_SIZE      = 2;
  localparam int ERR_PAYLEN    = 4;
  localparam int ST_MCAST      = 37;
  localparam int ST_PAUSE      = 35;
  localparam int ST_CTRL       = 34;
  localparam int ST_VLAN       = 33;

  // ==========================================================================
  // CRC-32, reflected form
  // ==========================================================================
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  typedef enum logic [1:0] {
    RXCP_IDLE  = 2'b01,
    RXCP_FRAME = 2'b10
  } rxcp_fsm_t;

endpackage

// ==== src/rxcp_crc.sv ====
`timescale 1ns/1ps
module rxcp_crc
  import rxcp_pkg::*;
#(
  parameter int DATA_W = 128,
  parameter int NB_W   = 5
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic              valid_i,
  input  wire logic              sop_i,
  input  wire logic [NB_W-1:0]   nbytes_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [31:0]       crc_next_o
);

  localparam int NB = DATA_W / 8;

  logic [31:0] crc_reg;

  // ==========================================================================
  // Byte-serial update, first byte in the top lane
  // ==========================================================================
  function automatic logic [31:0] crc_step(input logic [31:0]       c,
                                           input logic [DATA_W-1:0] d,
                                           input logic [NB_W-1:0]   n);
    logic [31:0] r;
    r = c;
    for (int k = 0; k < NB; k++) begin
      if (NB_W'(k) < n) begin
        for (int b = 0; b < 8; b++) begin
          r = (r >> 1) ^ ((r[0] ^ d[8*(NB-1-k)+b]) ? CRC_POLY : 32'h00000000);
        end
      end
    end
    return r;
  endfunction

  always_comb begin
    crc_next_o = crc_step(sop_i ? CRC_INIT : crc_reg, data_i, nbytes_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_reg <= CRC_INIT;
    end else if (ce_i && valid_i) begin
      crc_reg <= crc_next_o;
    end
  end

endmodule

// ==== src/rxcp_port.sv ====
// Overview of operation
// - A frame of 64 bytes or less may show start and end in one beat.
// - Six-bit error vector carries meaning only on the end-of-packet beat.
// - Bit 0 flags a non-terminate control character inside the frame.
// - Bit 1 flags bad CRC, error character, malformed or undersized frame.
// - Bit 2 flags a frame shorter than minimum or longer than maximum.
// - Frames of eight bytes or fewer are dropped silently, no error.
// - Same silent drop when delivered bytes after stripping are eight or fewer.
// - Bit 4 flags payload shorter than length field up to 1500, clean frames only; code also sets it beside a CRC or error-character bit 1.
// - Status qualifier high whenever the 40-bit status word is valid.
// - Status bit 37 marks broadcast or multicast destination.
// - Status bit 35 marks a PAUSE frame.
// - Status bit 34 marks type 0x8808 control frames.
// - Status bit 33 marks VLAN or stacked VLAN; other status bits reserved.
// - Preamble output valid on the beat with valid and start-of-packet.
// - Preamble port only at 128-bit width with passthrough on.
// - First packet byte always sits in the top byte lane.
// - Last beat reports unused byte lanes counted up from lane 0.
// - Last beat always has at least one valid byte.
// - All client signals run on the single receive clock.
// - Data bus is 512, 128 or 64 bits, bit 0 least significant.
// - Valid may drop inside a packet and means nothing outside one.
// - Start-of-packet marks the first beat, once per packet.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module rxcp_port
  import rxcp_pkg::*;
#(
  parameter int DATA_W  = 128,
  parameter int EMPTY_W = $clog2(DATA_W / 8),
  parameter int ADDR_W  = 8
) (
  input  wire logic               CLK_I,
  input  wire logic               RST_N_I,
  input  wire logic               CE_I,
  // Upstream decoded beats
  input  wire logic [DATA_W-1:0]  LANE_DATA_I,
  input  wire logic               LANE_VALID_I,
  input  wire logic               LANE_SOP_I,
  input  wire logic               LANE_EOP_I,
  input  wire logic [EMPTY_W-1:0] LANE_EMPTY_I,
  input  wire logic               LANE_CTRL_ERR_I,
  input  wire logic               LANE_ERR_CHAR_I,
  input  wire logic [PRE_W-1:0]   LANE_PREAMBLE_I,
  // Client stream
  output logic      [DATA_W-1:0]  RX_DATA_O,
  output logic                    RX_VALID_O,
  output logic                    RX_SOP_O,
  output logic                    RX_EOP_O,
  output logic      [EMPTY_W-1:0] RX_EMPTY_O,
  output logic      [5:0]         RX_ERROR_O,
  output logic                    RX_STATUS_VALID_O,
  output logic      [39:0]        RX_STATUS_DATA_O,
  output logic      [PRE_W-1:0]   RX_PREAMBLE_O,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]  AXI_AWADDR_I,
  input  wire logic               AXI_AWVALID_I,
  output logic                    AXI_AWREADY_O,
  input  wire logic [31:0]        AXI_WDATA_I,
  input  wire logic [3:0]         AXI_WSTRB_I,
  input  wire logic               AXI_WVALID_I,
  output logic                    AXI_WREADY_O,
  output logic      [1:0]         AXI_BRESP_O,
  output logic                    AXI_BVALID_O,
  input  wire logic               AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0]  AXI_ARADDR_I,
  input  wire logic               AXI_ARVALID_I,
  output logic                    AXI_ARREADY_O,
  output logic      [31:0]        AXI_RDATA_O,
  output logic      [1:0]         AXI_RRESP_O,
  output logic                    AXI_RVALID_O,
  input  wire logic               AXI_RREADY_I
);

  localparam int              NB     = DATA_W / 8;
  localparam int              NB_W   = EMPTY_W + 1;
  localparam logic [NB_W-1:0] NB_L   = NB_W'(NB);
  localparam bit              PRE_ON = (DATA_W == PRE_PORT_DATA_W);

  typedef struct packed {
    rxcp_fsm_t         st;
    logic [DATA_W-1:0] data;
    logic              valid;
    logic              sop;
    logic              eop;
    logic [EMPTY_W-1:0] empty;
    logic [5:0]        err;
    logic              sts_vld;
    logic [39:0]       sts;
    logic [PRE_W-1:0]  pre;
    logic [15:0]       cnt;
    logic [15:0]       ltype;
    logic [15:0]       opc;
    logic              mcast;
    logic              mal;
    logic              echr;
    logic              pt_en;
    logic [15:0]       maxlen;
    logic [31:0]       frames;
    logic [31:0]       errfrm;
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awrdy;
    logic              wrdy;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } rxcp_state_t;

  rxcp_state_t       s_reg;
  rxcp_state_t       s_next;
  logic [NB_W-1:0]   nb_w;
  logic [15:0]       base_w;
  logic [15:0]       tot_w;
  logic              runt_w;
  logic              accept_w;
  logic [31:0]       crc_w;

  // ==========================================================================
  // Register decode and byte-lane merge
  // ==========================================================================
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    case (8'(a))
      REG_CTRL_OFS:   reg_sel = 3'h1;
      REG_MAXLEN_OFS: reg_sel = 3'h2;
      REG_FRAMES_OFS: reg_sel = 3'h3;
      REG_ERRFRM_OFS: reg_sel = 3'h4;
      default:        reg_sel = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Beat bookkeeping
  // ==========================================================================
  assign nb_w     = LANE_EOP_I ? NB_L - {1'b0, LANE_EMPTY_I} : NB_L;
  assign base_w   = LANE_SOP_I ? 16'h0000 : s_reg.cnt;
  assign tot_w    = base_w + 16'(nb_w);
  assign runt_w   = LANE_SOP_I && LANE_EOP_I && (tot_w <= RUNT_MAX_BYTES);
  assign accept_w = LANE_VALID_I && !runt_w
                 && (LANE_SOP_I || s_reg.st == RXCP_FRAME);

  rxcp_crc #(
    .DATA_W (DATA_W),
    .NB_W   (NB_W)
  ) u_crc (
    .clk_i      (CLK_I),
    .rst_n_i    (RST_N_I),
    .ce_i       (CE_I),
    .valid_i    (accept_w),
    .sop_i      (LANE_SOP_I),
    .nbytes_i   (nb_w),
    .data_i     (LANE_DATA_I),
    .crc_next_o (crc_w)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    logic [15:0] pos;
    logic [7:0]  byte_v;
    logic        und;
    logic        ovr;
    logic        crc_bad;
    logic        vlan;
    logic [5:0]  ev;
    pos     = 16'h0000;
    byte_v  = 8'h00;
    und     = 1'b0;
    ovr     = 1'b0;
    crc_bad = 1'b0;
    vlan    = 1'b0;
    ev      = 6'h00;
    s_next  = s_reg;
    if (CE_I) begin
      s_next.valid   = 1'b0;
      s_next.sop     = 1'b0;
      s_next.eop     = 1'b0;
      s_next.sts_vld = 1'b0;
      s_next.err     = 6'h00;
      if (accept_w) begin
        if (LANE_SOP_I) begin
          s_next.ltype = 16'h0000;
          s_next.opc   = 16'h0000;
          s_next.mcast = 1'b0;
          s_next.mal   = 1'b0;
          s_next.echr  = 1'b0;
        end
        s_next.mal  = s_next.mal | LANE_CTRL_ERR_I;
        s_next.echr = s_next.echr | LANE_ERR_CHAR_I;
        for (int k = 0; k < NB; k++) begin
          if (NB_W'(k) < nb_w) begin
            pos    = base_w + 16'(k);
            byte_v = LANE_DATA_I[8*(NB-1-k) +: 8];
            case (pos)
              POS_DA0:     s_next.mcast      = byte_v[0];
              POS_TYPE_HI: s_next.ltype[15:8] = byte_v;
              POS_TYPE_LO: s_next.ltype[7:0]  = byte_v;
              POS_OPC_HI:  s_next.opc[15:8]   = byte_v;
              POS_OPC_LO:  s_next.opc[7:0]    = byte_v;
              default:     ;
            endcase
          end
        end
        s_next.data  = LANE_DATA_I;
        s_next.valid = 1'b1;
        s_next.sop   = LANE_SOP_I;
        s_next.eop   = LANE_EOP_I;
        s_next.empty = LANE_EOP_I ? LANE_EMPTY_I : '0;
        s_next.cnt   = tot_w;
        s_next.st    = LANE_EOP_I ? RXCP_IDLE : RXCP_FRAME;
        if (LANE_SOP_I && PRE_ON && s_reg.pt_en) begin
          s_next.pre = LANE_PREAMBLE_I;
        end
        if (LANE_EOP_I) begin
          und     = tot_w < MIN_FRAME_BYTES;
          ovr     = tot_w > s_reg.maxlen;
          crc_bad = crc_w != CRC_RESIDUE;
          vlan    = s_next.ltype == TPID_C || s_next.ltype == TPID_S
                 || s_next.ltype == TPID_Q;
          ev[ERR_MALFORMED] = s_next.mal;
          ev[ERR_CRC]  = crc_bad | s_next.echr | s_next.mal | und;
          ev[ERR_SIZE] = und | ovr;
          ev[ERR_PAYLEN] = !und && !ovr && !s_next.mal
                        && s_next.ltype <= LEN_FIELD_MAX
                        && (tot_w - HDR_FCS_BYTES) < s_next.ltype;
          s_next.err     = ev;
          s_next.sts_vld = 1'b1;
          s_next.sts     = 40'h0000000000;
          s_next.sts[ST_MCAST] = s_next.mcast;
          s_next.sts[ST_PAUSE] = s_next.ltype == TYPE_MAC_CTRL
                              && s_next.opc == OPC_PAUSE;
          s_next.sts[ST_CTRL]  = s_next.ltype == TYPE_MAC_CTRL;
          s_next.sts[ST_VLAN]  = vlan;
          s_next.frames = s_reg.frames + 32'h00000001;
          if (ev != 6'h00) begin
            s_next.errfrm = s_reg.errfrm + 32'h00000001;
          end
        end
      end
      // AXI4-Lite write channel
      if (s_reg.bvalid && AXI_BREADY_I) begin
        s_next.bvalid = 1'b0;
      end
      if (AXI_AWVALID_I && s_reg.awrdy) begin
        s_next.aw_have = 1'b1;
        s_next.aw_addr = AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && s_reg.wrdy) begin
        s_next.w_have = 1'b1;
        s_next.wdata  = AXI_WDATA_I;
        s_next.wstrb  = AXI_WSTRB_I;
      end
      if (s_next.aw_have && s_next.w_have && !s_next.bvalid) begin
        s_next.aw_have = 1'b0;
        s_next.w_have  = 1'b0;
        s_next.bvalid  = 1'b1;
        s_next.bresp   = RESP_OKAY;
        case (reg_sel(s_next.aw_addr))
          3'h1: s_next.pt_en  = 1'(wmerge({31'h0, s_reg.pt_en}, s_next.wdata,
                                          s_next.wstrb) >> CTRL_PT_BIT);
          3'h2: s_next.maxlen = 16'(wmerge({16'h0000, s_reg.maxlen}, s_next.wdata,
                                           s_next.wstrb));
          3'h3,
          3'h4: ;
          default: s_next.bresp = RESP_DECERR;
        endcase
      end
      s_next.awrdy = !s_next.aw_have && !s_next.bvalid;
      s_next.wrdy  = !s_next.w_have && !s_next.bvalid;
      // AXI4-Lite read channel
      if (s_reg.rvalid && AXI_RREADY_I) begin
        s_next.rvalid = 1'b0;
      end
      if (AXI_ARVALID_I && s_reg.arrdy) begin
        s_next.rvalid = 1'b1;
        s_next.rresp  = RESP_OKAY;
        case (reg_sel(AXI_ARADDR_I))
          3'h1:    s_next.rdata = 32'(s_reg.pt_en) << CTRL_PT_BIT;
          3'h2:    s_next.rdata = {16'h0000, s_reg.maxlen};
          3'h3:    s_next.rdata = s_reg.frames;
          3'h4:    s_next.rdata = s_reg.errfrm;
          default: begin
            s_next.rdata = 32'h00000000;
            s_next.rresp = RESP_DECERR;
          end
        endcase
      end
      s_next.arrdy = !s_next.rvalid;
    end
  end

  // ==========================================================================
  // State register, single receive clock
  // ==========================================================================
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_reg        <= '0;
      s_reg.st     <= RXCP_IDLE;
      s_reg.maxlen <= MAXLEN_RST;
      s_reg.awrdy  <= 1'b1;
      s_reg.wrdy   <= 1'b1;
      s_reg.arrdy  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RX_DATA_O         = s_reg.data;
  assign RX_VALID_O        = s_reg.valid;
  assign RX_SOP_O          = s_reg.sop;
  assign RX_EOP_O          = s_reg.eop;
  assign RX_EMPTY_O        = s_reg.empty;
  assign RX_ERROR_O        = s_reg.err;
  assign RX_STATUS_VALID_O = s_reg.sts_vld;
  assign RX_STATUS_DATA_O  = s_reg.sts;
  assign RX_PREAMBLE_O     = s_reg.pre;
  assign AXI_AWREADY_O     = s_reg.awrdy;
  assign AXI_WREADY_O      = s_reg.wrdy;
  assign AXI_BRESP_O       = s_reg.bresp;
  assign AXI_BVALID_O      = s_reg.bvalid;
  assign AXI_ARREADY_O     = s_reg.arrdy;
  assign AXI_RDATA_O       = s_reg.rdata;
  assign AXI_RRESP_O       = s_reg.rresp;
  assign AXI_RVALID_O      = s_reg.rvalid;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_end_beat;
    CE_I && accept_w && LANE_EOP_I;
  endsequence

  sequence s_ctrl_end;
    CE_I && accept_w && LANE_EOP_I
    && (LANE_CTRL_ERR_I || (s_reg.mal && !LANE_SOP_I));
  endsequence

  err_eop_only_a:  assert property (RX_VALID_O && !RX_EOP_O |-> RX_ERROR_O == 6'h00)
    else $error("Error vector set outside end beat");
  status_qual_a:   assert property (s_end_beat |=> RX_STATUS_VALID_O && RX_EOP_O)
    else $error("Status qualifier missing on end beat");
  malformed_bit_a: assert property (s_ctrl_end |=> RX_ERROR_O[0] && RX_ERROR_O[1])
    else $error("Malformed frame not flagged");
  reserved_zero_a: assert property (RX_STATUS_DATA_O[39:38] == 2'h0 && !RX_STATUS_DATA_O[36]
                                    && RX_STATUS_DATA_O[32:0] == 33'h0
                                    && !RX_ERROR_O[3] && !RX_ERROR_O[5])
    else $error("Reserved bit driven high");
  runt_drop_a:     assert property (CE_I && LANE_VALID_I && LANE_SOP_I && LANE_EOP_I
                                    && tot_w <= RUNT_MAX_BYTES |=> !RX_VALID_O)
    else $error("Runt frame delivered");
  empty_range_a:   assert property (RX_VALID_O && RX_EOP_O |-> 32'(RX_EMPTY_O) < NB)
    else $error("Empty count covers whole bus");
  paylen_clean_a:  assert property (RX_ERROR_O[4] |-> !RX_ERROR_O[2] && !RX_ERROR_O[0])
    else $error("Length error on bad frame");
  size_err_a:      assert property (s_end_beat and (tot_w < MIN_FRAME_BYTES)
                                    |=> RX_ERROR_O[2] && RX_ERROR_O[1])
    else $error("Undersized frame not flagged");
  data_pass_a:     assert property (CE_I && accept_w
                                    |=> RX_VALID_O && RX_DATA_O == $past(LANE_DATA_I))
    else $error("Beat not forwarded");
  preamble_a:      assert property (CE_I && accept_w && LANE_SOP_I && s_reg.pt_en && PRE_ON
                                    |=> RX_PREAMBLE_O == $past(LANE_PREAMBLE_I))
    else $error("Preamble not presented");
  ce_freeze_a:     assert property (!CE_I |=> $stable(RX_VALID_O) && $stable(RX_DATA_O))
    else $error("State moved with clock enable low");

endmodule

// ==== dv/rxcp_sink.sv ====
`timescale 1ns/1ps
module rxcp_sink
  import rxcp_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         valid_i,
  input  wire logic         sop_i,
  input  wire logic         eop_i,
  input  wire logic         stv_i,
  input  wire logic [127:0] data_i,
  input  wire logic [3:0]   empty_i,
  input  wire logic [5:0]   err_i,
  input  wire logic [39:0]  stat_i,
  input  wire logic [63:0]  pre_i,
  output int                n_eop_o,
  output int                n_bad_o,
  output logic              one_o,
  output logic [7:0]        top_o,
  output logic [3:0]        emp_o,
  output logic [5:0]        err_o,
  output logic [39:0]       st_o,
  output logic [63:0]       pre_o
);
  // Takes every beat, never stalls the source
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      n_eop_o <= 0;
      n_bad_o <= 0;
    end else begin
      if (stv_i !== (valid_i && eop_i)) n_bad_o <= n_bad_o + 1;
      if (valid_i && sop_i) begin
        top_o <= data_i[127:120];
        pre_o <= pre_i;
      end
      if (valid_i && eop_i) begin
        n_eop_o <= n_eop_o + 1;
        one_o   <= sop_i;
        emp_o   <= empty_i;
        err_o   <= err_i;
        st_o    <= stat_i;
      end
    end
  end
endmodule

// ==== dv/rx_mac_stream_client_port_bench.sv ====
`timescale 1ns/1ps
module rx_mac_stream_client_port_bench;
  import rxcp_pkg::*;
  logic clk, rst_n, v, s, e, cer, ech, awv, wv, br, arv, rr, one, ce;
  logic [127:0] d, rdat;
  logic [3:0]   emp, remp, lemp;
  logic [63:0]  pre, rpre, lpre;
  logic [7:0]   awa, ara, top;
  logic [31:0]  wd, rdata, x, fcs;
  logic [5:0]   rerr, lerr;
  logic [39:0]  std, lst;
  logic [1:0]   bresp, rresp, r;
  logic         rv, rs, re, stv, awr, wr_r, bv, arr, rvld;
  int           n_eop, n_bad, bad_count, comparisons;

  rxcp_port #(.DATA_W(128)) rxcp_port_inst (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .LANE_DATA_I(d), .LANE_VALID_I(v), .LANE_SOP_I(s), .LANE_EOP_I(e), .LANE_EMPTY_I(emp),
    .LANE_CTRL_ERR_I(cer), .LANE_ERR_CHAR_I(ech), .LANE_PREAMBLE_I(pre), .RX_DATA_O(rdat),
    .RX_VALID_O(rv), .RX_SOP_O(rs), .RX_EOP_O(re), .RX_EMPTY_O(remp), .RX_ERROR_O(rerr),
    .RX_STATUS_VALID_O(stv), .RX_STATUS_DATA_O(std), .RX_PREAMBLE_O(rpre),
    .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_WDATA_I(wd),
    .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wv), .AXI_WREADY_O(wr_r), .AXI_BRESP_O(bresp),
    .AXI_BVALID_O(bv), .AXI_BREADY_I(br), .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv),
    .AXI_ARREADY_O(arr), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvld),
    .AXI_RREADY_I(rr));
  rxcp_sink rxcp_sink_inst (.clk_i(clk), .rst_n_i(rst_n), .valid_i(rv), .sop_i(rs),
    .eop_i(re), .stv_i(stv), .data_i(rdat), .empty_i(remp), .err_i(rerr), .stat_i(std),
    .pre_i(rpre), .n_eop_o(n_eop), .n_bad_o(n_bad), .one_o(one), .top_o(top),
    .emp_o(lemp), .err_o(lerr), .st_o(lst), .pre_o(lpre));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task summarize();
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input string n, input logic [63:0] xp, input logic [63:0] g);
    comparisons++;
    if (g !== xp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, xp, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] xr);
    int i;
    awa <= a; wd <= dv; awv <= 1; wv <= 1; br <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_r) wv <= 0;
      if (bv) break;
    end
    if (i == 50) begin bad_count++; summarize(); end
    chk("bresp", xr, bresp);
    br <= 0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a);
    int i;
    ara <= a; arv <= 1; rr <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rvld) break;
    end
    if (i == 50) begin bad_count++; summarize(); end
    x = rdata; r = rresp; rr <= 0;
    @(posedge clk);
  endtask
  task frame(input logic [127:0] f, input int nb, input logic [3:0] m, input logic c,
             input int xn);
    int i, k;
    k = n_eop;
    for (i = 0; i < nb; i++) begin
      d <= ((i == 0) ? f : 128'h0) | ((i == nb - 1) ? {96'h0, fcs} : 128'h0);
      v <= 1; s <= (i == 0); e <= (i == nb - 1);
      emp <= m; cer <= c && (i == nb - 1);
      @(posedge clk);
    end
    v <= 0; s <= 0; e <= 0; cer <= 0;
    for (i = 0; i < 20 && n_eop == k; i++) @(posedge clk);
    chk("frames", 64'(xn), 64'(n_eop - k));
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_regs();
    rd(REG_MAXLEN_OFS); chk("maxlen", 64'(MAXLEN_RST), 64'(x));
    rd(8'h40); chk("rresp", 64'h3, 64'(r));
    wr(REG_CTRL_OFS, 32'h1, RESP_OKAY);
    rd(REG_CTRL_OFS); chk("ctrl", 64'h1, 64'(x));
    $display("regs done");
  endtask
  task t_pause();
    frame({48'hFFFF_FFFF_FFFF, 48'h0, TYPE_MAC_CTRL, OPC_PAUSE}, 4, 4'h0, 1'b0, 1);
    chk("err", 64'h02, 64'(lerr));
    chk("stat", 64'h2C_0000_0000, 64'(lst));
    chk("pre", pre, lpre);
    chk("top", 64'hFF, 64'(top));
    $display("pause done");
  endtask
  task t_short();
    frame({48'h0200_0000_0000, 48'h0, 16'h0800, 16'h0}, 1, 4'h4, 1'b0, 1);
    chk("one", 64'h1, 64'(one));
    chk("empty", 64'h4, 64'(lemp));
    chk("err", 64'h06, 64'(lerr));
    frame(128'h0, 1, 4'h8, 1'b0, 0);
    $display("short done");
  endtask
  task t_vlan();
    frame({96'h0, TPID_C, 16'h0}, 5, 4'h3, 1'b1, 1);
    chk("err", 64'h03, 64'(lerr));
    chk("stat", 64'h02_0000_0000, 64'(lst));
    chk("empty", 64'h3, 64'(lemp));
    frame({96'h0, 16'h0064, 16'h0}, 4, 4'h0, 1'b0, 1);
    chk("err", 64'h12, 64'(lerr));
    $display("vlan done");
  endtask
  // FCS for a 64-byte frame: one header beat, zero fill, FCS in the last four lanes
  function automatic logic [31:0] fcs_of(input logic [127:0] f);
    logic [31:0] c;
    logic [7:0]  b;
    c = CRC_INIT;
    for (int k = 0; k < 60; k++) begin
      b = (k < 16) ? f[8*(15-k) +: 8] : 8'h00;
      for (int j = 0; j < 8; j++) begin
        c = (c >> 1) ^ ((c[0] ^ b[j]) ? CRC_POLY : 32'h00000000);
      end
    end
    c = ~c;
    return {c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction
  task t_good();
    logic [127:0] g;
    g = {48'h0000_0000_0001, 48'h0, 16'h0800, 16'h0};
    fcs = fcs_of(g);
    frame(g, 4, 4'h0, 1'b0, 1);
    chk("err", 64'h00, 64'(lerr));
    chk("stat", 64'h0, 64'(lst));
    ech <= 1'b1;
    frame(g, 4, 4'h0, 1'b0, 1);
    ech <= 1'b0;
    chk("err", 64'h02, 64'(lerr));
    fcs = '0;
    ce <= 1'b0;
    frame(g, 1, 4'h0, 1'b0, 0);
    ce <= 1'b1;
    wr(REG_MAXLEN_OFS, 32'h0000_0040, RESP_OKAY);
    wr(8'h40, 32'h0000_0000, RESP_DECERR);
    frame(g, 5, 4'h3, 1'b0, 1);
    chk("err", 64'h06, 64'(lerr));
    $display("good done");
  endtask

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst_n = 0; v = 0; s = 0; e = 0; cer = 0; ech = 0; d = '0; emp = '0;
    pre = 64'h5555_5555_5555_55D5; awa = '0; ara = '0; wd = '0;
    awv = 0; wv = 0; br = 0; arv = 0; rr = 0; bad_count = 0; comparisons = 0;
    ce = 1;
    fcs = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs();
    t_pause();
    t_short();
    t_vlan();
    t_good();
    chk("stv", 64'h0, 64'(n_bad));
    summarize();
  end
endmodule
